// File: shared/line_regs_pkg.sv
// Package for the line-side status and gain register bank.
// Assumes an AXI4-Lite master with 32-bit data and word-aligned registers.
package line_regs_pkg;
   // Printed offsets are register indices; byte address is four times the index.
   localparam logic [7:0] IDX_STATUS    = 8'h0C;
   localparam logic [7:0] IDX_REVISION  = 8'h0D;
   localparam logic [7:0] IDX_RSVD_14   = 8'h0E;
   localparam logic [7:0] IDX_GAIN_CTRL = 8'h0F;
   localparam logic [7:0] IDX_RSVD_16   = 8'h10;
   localparam logic [7:0] IDX_CAL_CTRL  = 8'h11;
   localparam logic [7:0] IDX_IRQ_STAT  = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK  = 8'h21;
   localparam int         ADDR_W        = 10;

   localparam int STAT_LOCK_BIT   = 6;
   localparam int STAT_LOOP_LSB   = 0;
   localparam int REV_LSB         = 2;
   localparam int GAIN_TXM_BIT    = 7;
   localparam int GAIN_ATX_LSB    = 4;
   localparam int GAIN_RXM_BIT    = 3;
   localparam int GAIN_ARX_LSB    = 0;
   localparam int CAL_ADC_CAL_DISABLE_BIT    = 5;

   localparam logic [7:0] GAIN_RESET  = 8'h00;
   localparam logic [7:0] CAL_RESET   = 8'h00;
   localparam logic [7:0] GAIN_WMASK  = 8'hFF;
   localparam logic [7:0] CAL_WMASK   = 8'h20;
   localparam logic [2:0] IRQ_WMASK   = 3'h7;
   // Arbitrary neutral revision value.
   localparam logic [3:0] REV_DEFAULT = 4'h3;

   localparam logic [4:0] LOOP_LOW_MAX = 5'h03;
   localparam logic [4:0] LOOP_MIN_OK  = 5'h04;
   localparam logic [4:0] LOOP_OVER    = 5'h1F;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Interrupt status bits: lock gained, lock lost, loop current change.
   localparam int IRQ_W = 3;

   typedef enum logic [2:0] {
      LOOP_LOW  = 3'b001,
      LOOP_OK   = 3'b010,
      LOOP_HIGH = 3'b100
   } loop_class_e;

   typedef struct packed {
      logic       mute;
      logic [4:0] level_db;
   } path_gain_s;
endpackage

// File: hw/gain_step.sv
// Decodes a three-bit gain selector into a dB level and passes the mute bit through unchanged.
// Assumes the selector is stable in register flops of the caller.
`timescale 1ns/100ps
module gain_step
   import line_regs_pkg::*;
(
   input  wire logic       mute,
   input  wire logic [2:0] sel,
   output path_gain_s      gain
);
   always_comb begin
      gain.mute = mute; // RULE_06 RULE_07
      if (sel[2]) begin
         gain.level_db = 5'd12; // RULE_08
      end else begin
         gain.level_db = 5'(sel[1:0] * 3); // RULE_08
      end
   end
endmodule

// File: hw/line_side_status_gain_regs.sv
// Line-side status, revision, gain and calibration registers behind AXI4-Lite.
// Assumes lock and loop-current inputs synchronous to aclk, one outstanding access per channel.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps

// Functional notes
// RULE_01 - Lock bit reads 1 while the capacitor link is frame locked.
// RULE_02 - Off-hook, five-bit loop field reports current at 3.3 mA per step.
// RULE_03 - Codes 0 to 3 mean too little current; code 4 is minimum.
// RULE_04 - Codes 5 to 30 are normal; all ones means above 160 mA.
// RULE_05 - Revision register bits 5:2 return the read-only line-side revision.
// RULE_06 - Transmit-mute bit silences transmit; clear passes transmit.
// RULE_07 - Receive-mute bit silences receive; clear passes receive.
// RULE_08 - Gain fields step 3 dB per code to 011; top bit set gives 12 dB.
// RULE_09 - Calibration-disable bit set prevents ADC calibration.
// RULE_10 - Software writes zero to reserved bits and ignores their read value.
// RULE_11 - Gain register resets to zero: unmuted, 0 dB both ways.
// RULE_12 - Writes to status and revision registers are ignored.
module line_side_status_gain_regs
   import line_regs_pkg::*;
#(
   parameter logic [3:0] REVISION = REV_DEFAULT
)(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              frame_locked,
   input  wire logic              off_hook,
   input  wire logic [4:0]        loop_current_meas,
   input  wire logic              cal_request,
   output logic                   adc_cal_start,
   output path_gain_s             tx_gain,
   output path_gain_s             rx_gain,
   output loop_class_e            loop_class,
   output logic                   irq
);
   typedef struct packed {
      logic              aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;
      logic [7:0]        w_data;
      logic              w_lane0;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [7:0]        gain_ctrl;
      logic [7:0]        cal_ctrl;
      logic              lock_prev;
      logic [4:0]        loop_prev;
      logic [IRQ_W-1:0]  irq_stat;
      logic [IRQ_W-1:0]  irq_mask;
      logic              cal_pulse;
   } state_s;

   state_s cur;
   state_s next_cur;

   logic [7:0]       status_byte;
   logic [7:0]       revision_byte;
   logic [7:0]       rd_idx;
   logic [7:0]       wr_idx;
   logic [IRQ_W-1:0] events;
   logic             do_write;
   logic             do_read;

   // Loop code is meaningful only off-hook; on-hook reads as zero.
   always_comb begin
      status_byte = 8'h00;
      status_byte[STAT_LOCK_BIT] = frame_locked; // RULE_01
      if (off_hook) begin
         status_byte[STAT_LOOP_LSB +: 5] = loop_current_meas; // RULE_02
      end
      revision_byte = 8'h00;
      revision_byte[REV_LSB +: 4] = REVISION; // RULE_05
   end

   always_comb begin
      if (!off_hook || loop_current_meas <= LOOP_LOW_MAX) begin
         loop_class = LOOP_LOW; // RULE_03
      end else if (loop_current_meas == LOOP_OVER) begin
         loop_class = LOOP_HIGH; // RULE_04
      end else begin
         loop_class = LOOP_OK; // RULE_03 RULE_04
      end
   end

   gain_step u_tx_step (
      .mute (cur.gain_ctrl[GAIN_TXM_BIT]),
      .sel  (cur.gain_ctrl[GAIN_ATX_LSB +: 3]),
      .gain (tx_gain)
   );

   gain_step u_rx_step (
      .mute (cur.gain_ctrl[GAIN_RXM_BIT]),
      .sel  (cur.gain_ctrl[GAIN_ARX_LSB +: 3]),
      .gain (rx_gain)
   );

   assign rd_idx   = s_axi_araddr[ADDR_W-1:2];
   assign wr_idx   = cur.aw_addr[ADDR_W-1:2];
   assign do_write = cur.aw_held && cur.w_held && !cur.bvalid;
   assign do_read  = s_axi_arvalid && !cur.rvalid;

   // Events: lock gained, lock lost, off-hook loop code changed.
   assign events[0] = frame_locked && !cur.lock_prev;
   assign events[1] = !frame_locked && cur.lock_prev;
   assign events[2] = off_hook && (loop_current_meas != cur.loop_prev);

   always_comb begin
      next_cur = cur;
      next_cur.lock_prev = frame_locked;
      next_cur.loop_prev = off_hook ? loop_current_meas : cur.loop_prev;
      next_cur.cal_pulse = cal_request && !cur.cal_ctrl[CAL_ADC_CAL_DISABLE_BIT]; // RULE_09

      if (s_axi_awvalid && !cur.aw_held) begin
         next_cur.aw_held = 1'b1;
         next_cur.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !cur.w_held) begin
         next_cur.w_held  = 1'b1;
         next_cur.w_data  = s_axi_wdata[7:0];
         next_cur.w_lane0 = s_axi_wstrb[0];
      end

      if (do_write) begin
         next_cur.aw_held = 1'b0;
         next_cur.w_held  = 1'b0;
         next_cur.bvalid  = 1'b1;
         next_cur.bresp   = RESP_OKAY;
         case (wr_idx)
            IDX_GAIN_CTRL: begin
               if (cur.w_lane0) begin
                  next_cur.gain_ctrl = cur.w_data & GAIN_WMASK; // RULE_06 RULE_07 RULE_08
               end
            end
            IDX_CAL_CTRL: begin
               if (cur.w_lane0) begin
                  next_cur.cal_ctrl = cur.w_data & CAL_WMASK; // RULE_09
               end
            end
            IDX_IRQ_MASK: begin
               if (cur.w_lane0) begin
                  next_cur.irq_mask = cur.w_data[IRQ_W-1:0] & IRQ_WMASK;
               end
            end
            IDX_STATUS, IDX_REVISION, IDX_RSVD_14, IDX_RSVD_16, IDX_IRQ_STAT: begin
               next_cur.bresp = RESP_OKAY; // RULE_12
            end
            default: begin
               next_cur.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (cur.bvalid && s_axi_bready) begin
         next_cur.bvalid = 1'b0;
      end

      // Read of the interrupt status register clears; new events still win.
      if (do_read) begin
         next_cur.rvalid = 1'b1;
         next_cur.rresp  = RESP_OKAY;
         next_cur.rdata  = 32'h0000_0000;
         case (rd_idx)
            IDX_STATUS:    next_cur.rdata[7:0] = status_byte;
            IDX_REVISION:  next_cur.rdata[7:0] = revision_byte;
            IDX_RSVD_14:   next_cur.rdata[7:0] = 8'h00;
            IDX_GAIN_CTRL: next_cur.rdata[7:0] = cur.gain_ctrl;
            IDX_RSVD_16:   next_cur.rdata[7:0] = 8'h00;
            IDX_CAL_CTRL:  next_cur.rdata[7:0] = cur.cal_ctrl;
            IDX_IRQ_STAT: begin
               next_cur.rdata[IRQ_W-1:0] = cur.irq_stat;
               next_cur.irq_stat = '0;
            end
            IDX_IRQ_MASK:  next_cur.rdata[IRQ_W-1:0] = cur.irq_mask;
            default:       next_cur.rresp = RESP_SLVERR;
         endcase
      end
      if (cur.rvalid && s_axi_rready) begin
         next_cur.rvalid = 1'b0;
      end
      next_cur.irq_stat = next_cur.irq_stat | events;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cur           <= '0;
         cur.gain_ctrl <= GAIN_RESET; // RULE_11
         cur.cal_ctrl  <= CAL_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   assign s_axi_awready = !cur.aw_held;
   assign s_axi_wready  = !cur.w_held;
   assign s_axi_bvalid  = cur.bvalid;
   assign s_axi_bresp   = cur.bresp;
   assign s_axi_arready = !cur.rvalid;
   assign s_axi_rvalid  = cur.rvalid;
   assign s_axi_rdata   = cur.rdata;
   assign s_axi_rresp   = cur.rresp;
   assign adc_cal_start = cur.cal_pulse;
   assign irq           = |(cur.irq_stat & cur.irq_mask);
endmodule

// File: verification/line_regs_asserts.sv
// Concurrent checks on the ports of the line-side register bank.
// Assumes one clock domain and a bind to every instance of the bank.
`timescale 1ns/100ps
module line_regs_asserts
   import line_regs_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        off_hook,
   input wire logic [4:0]  loop_current_meas,
   input loop_class_e      loop_class,
   input path_gain_s       tx_gain,
   input path_gain_s       rx_gain,
   input wire logic        cal_request,
   input wire logic        adc_cal_start,
   input wire logic        irq,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence read_taken; s_axi_arvalid && s_axi_arready; endsequence
   sequence read_answer; s_axi_rvalid; endsequence
   a_loop_low: assert property (!off_hook || loop_current_meas <= 5'h03 |-> loop_class == LOOP_LOW)
      else $error("loop class not low");
   a_loop_over: assert property (off_hook && loop_current_meas == 5'h1F |-> loop_class == LOOP_HIGH)
      else $error("loop class not high");
   a_loop_normal: assert property (off_hook && loop_current_meas inside {[5'h04:5'h1E]}
      |-> loop_class == LOOP_OK) else $error("loop class not normal");
   a_gain_steps: assert property (tx_gain.level_db % 3 == 0 && tx_gain.level_db <= 5'h0C
      && rx_gain.level_db % 3 == 0 && rx_gain.level_db <= 5'h0C) else $error("bad level");
   a_reset_gain: assert property ($rose(aresetn) |-> tx_gain == '0 && rx_gain == '0 && !irq)
      else $error("gain not zero after reset");
   a_cal_cause: assert property (adc_cal_start |-> $past(cal_request))
      else $error("calibration start without request");
   a_read_latency: assert property (read_taken |=> read_answer) else $error("read answer late");
   a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
endmodule

bind line_side_status_gain_regs line_regs_asserts u_chk (.aclk, .aresetn, .off_hook,
   .loop_current_meas, .loop_class, .tx_gain, .rx_gain, .cal_request, .adc_cal_start, .irq,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid,
   .s_axi_bready);

// File: verification/line_side_status_gain_regs_tb.sv
// Self-checking bench for the line-side register bank over AXI4-Lite.
// Assumes the package and the checker are compiled before this file.
`timescale 1ns/100ps
module line_side_status_gain_regs_tb;
   import line_regs_pkg::*;
   localparam logic [3:0] REV = 4'h5; // Arbitrary revision value.
   logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, irq, adc_cal_start;
   logic        frame_locked = 1'h0, off_hook = 1'h0, cal_request = 1'h0;
   logic        bready = 1'h1, rready = 1'h1;
   logic [9:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [1:0]  bresp, rresp;
   logic [4:0]  meas = '0;
   logic [7:0]  g;
   logic [4:0]  codes [6] = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h1E, 5'h1F};
   path_gain_s  tx_gain, rx_gain;
   loop_class_e loop_class;
   int          failures = 0, n_compared = 0;
   always #50 aclk = ~aclk;
   line_side_status_gain_regs #(.REVISION(REV)) dut (.aclk, .aresetn, .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_locked, .off_hook,
      .loop_current_meas(meas), .cal_request, .adc_cal_start, .tx_gain, .rx_gain, .loop_class, .irq);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      if (failures == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic [4:0] lvl(input logic [2:0] s);
      return s[2] ? 5'h0C : 5'(3 * s[1:0]);
   endfunction
   // Offers address and data together and releases each once taken.
   task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ah, wh, bh;
      bh = 1'h0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!bh) begin
         @(negedge aclk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid;
         if (bh) chk(32'(bresp), 32'(er));
         @(posedge aclk);
         if (ah) awvalid <= 1'h0;
         if (wh) wvalid <= 1'h0;
      end
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ah, rh;
      rh = 1'h0;
      araddr <= a;
      arvalid <= 1'h1;
      while (!rh) begin
         @(negedge aclk);
         ah = arvalid && arready;
         rh = rvalid;
         if (rh) chk(rdata, e);
         if (rh) chk(32'(rresp), 32'(er));
         @(posedge aclk);
         if (ah) arvalid <= 1'h0;
      end
   endtask
   initial begin
      #1_000_000;
      failures++;
      test_done();
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      rd(10'h03C, 32'h0, RESP_OKAY);
      chk(32'({tx_gain, rx_gain}), 32'h0);
      rd(10'h044, 32'h0, RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
         g = {i[0], 3'(i), ~i[0], 3'(7 - i)};
         wr(10'h03C, {24'h0, g}, RESP_OKAY);
         rd(10'h03C, {24'h0, g}, RESP_OKAY);
         chk(32'(tx_gain), 32'({i[0], lvl(3'(i))}));
         chk(32'(rx_gain), 32'({~i[0], lvl(3'(7 - i))}));
      end
      off_hook <= 1'h1;
      for (int i = 0; i < 6; i++) begin
         meas <= codes[i];
         frame_locked <= i[0];
         @(posedge aclk);
         rd(10'h030, {25'h0, i[0], 1'h0, codes[i]}, RESP_OKAY);
         chk(32'(loop_class), 32'(i < 2 ? LOOP_LOW : i == 5 ? LOOP_HIGH : LOOP_OK));
      end
      off_hook <= 1'h0;
      @(posedge aclk);
      rd(10'h030, 32'h40, RESP_OKAY);
      chk(32'(loop_class), 32'(LOOP_LOW));
      wr(10'h030, 32'hFF, RESP_OKAY);
      rd(10'h030, 32'h40, RESP_OKAY);
      wr(10'h034, 32'hFF, RESP_OKAY);
      rd(10'h034, {26'h0, REV, 2'h0}, RESP_OKAY);
      wr(10'h038, 32'h0, RESP_OKAY);
      rd(10'h040, 32'h0, RESP_OKAY);
      wr(10'h100, 32'h0, RESP_SLVERR);
      rd(10'h100, 32'h0, RESP_SLVERR);
      wr(10'h044, 32'h20, RESP_OKAY);
      rd(10'h044, 32'h20, RESP_OKAY);
      for (int i = 0; i < 2; i++) begin
         cal_request <= 1'h1;
         @(posedge aclk);
         cal_request <= 1'h0;
         @(negedge aclk);
         chk(32'(adc_cal_start), 32'(i));
         @(posedge aclk);
         wr(10'h044, 32'h0, RESP_OKAY);
      end
      frame_locked <= 1'h0;
      repeat (3) @(posedge aclk);
      rd(10'h080, 32'h7, RESP_OKAY);
      frame_locked <= 1'h1;
      repeat (3) @(negedge aclk);
      chk(32'(irq), 32'h0);
      @(posedge aclk);
      wr(10'h084, 32'h1, RESP_OKAY);
      @(negedge aclk);
      chk(32'(irq), 32'h1);
      @(posedge aclk);
      rd(10'h080, 32'h1, RESP_OKAY);
      @(negedge aclk);
      chk(32'(irq), 32'h0);
      // Stalled answers must stand until the master takes them.
      bready <= 1'h0;
      rready <= 1'h0;
      wr(10'h03C, 32'h0, RESP_OKAY);
      rd(10'h03C, 32'h0, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(32'({bvalid, rvalid}), 32'h3);
      bready <= 1'h1;
      rready <= 1'h1;
      @(posedge aclk);
      @(negedge aclk);
      chk(32'({bvalid, rvalid}), 32'h0);
      test_done();
   end
endmodule
